// [core/adcs_params.svh]
// Constants of the converter control sequencer: offsets, fields, resets,
// divider counts. Included by the package user files; definitions only.
// Operation
// - Conversion clock is oscillator/2,8,32,4,16,64 or internal RC per select.
// - Channel field, bits 5..3 of main control, picks input 0..7.
// - Writing go while powered starts conversion; bit reads one meanwhile.
// - Go bit reads zero whenever no conversion is running.
// - Completion loads result, clears go bit 2, sets the interrupt flag.
// - Main control bit 0 powers the converter up; zero shuts it off.
// - Main bit 1 and format bits 5..4 always read zero.
// - Format bit picks right or left justification, other bits zero.
// - Four-bit port field sets analog/digital pins by fixed table.
// - References are supplies or input pins three and two per code.
// - Any reset forces all shared pins to analog input mode.
// - Reset clears all control bits, powers off, aborts conversion.
// - Conversion continues in sleep only with the internal RC clock.
// - Result is a 10-bit unsigned value of the selected input.
// - Result found by successive approximation on the held sample.
// - Small variant has five analog inputs, large variant eight.
// - Each conversion takes twelve conversion-clock periods.
// - Power-on reset leaves the result registers unchanged.
`ifndef ADCS_PARAMS_SVH
`define ADCS_PARAMS_SVH

`define ADCS_OFF_MAIN    3'h0
`define ADCS_OFF_FMT     3'h1
`define ADCS_OFF_RESH    3'h2
`define ADCS_OFF_RESL    3'h3
`define ADCS_OFF_FLAG    3'h4

`define ADCS_MAIN_POWER  0
`define ADCS_MAIN_GO     2
`define ADCS_FMT_RIGHT   7
`define ADCS_FMT_CLKHI   6
`define ADCS_FLAG_BIT    0

`define ADCS_MAIN_RESET  8'h00
`define ADCS_FMT_RESET   8'h00
`define ADCS_MASK_RESET  8'hff

`define ADCS_DIV_2       16'h0002
`define ADCS_DIV_4       16'h0004
`define ADCS_DIV_8       16'h0008
`define ADCS_DIV_16      16'h0010
`define ADCS_DIV_32      16'h0020
`define ADCS_DIV_64      16'h0040
`define ADCS_RC_DIV      200
`define ADCS_CONV_TADS   12
`define ADCS_LAST_STEP   4'hb
`define ADCS_TOP_TRIAL   10'h200

`endif

// [core/adcs_pkg.sv]
// Types shared by the converter control sequencer.
// Assumes the constants header is included by the design files.
package adcs_pkg;
  typedef enum logic {adcs_idle, adcs_conv} adcs_state_t;
  typedef logic [9:0] adcs_result_t;
endpackage

// [core/adcs_tad_div.sv]
// Conversion clock divider: one-cycle tick every period cycles.
// Assumes period is at least two and stable while running.
`timescale 1ns/1ps
`default_nettype none
module adcs_tad_div #(
  parameter int W = 16
) (
  input  wire logic         clk,
  input  wire logic         sys_rst,
  input  wire logic         clr,
  input  wire logic         en,
  input  wire logic [W-1:0] period,
  output var  logic         tick
);
  logic [W-1:0] cnt;

  always_ff @(posedge clk) begin
    if (sys_rst || clr) begin
      cnt  <= '0;
      tick <= 1'b0;
    end else if (en) begin
      if (cnt >= period - W'(1)) begin
        cnt  <= '0;
        tick <= 1'b1;
      end else begin
        cnt  <= cnt + W'(1);
        tick <= 1'b0;
      end
    end else begin
      tick <= 1'b0; // Stalled clock holds the count
    end
  end

  tick_gap_a: assert property (@(posedge clk) disable iff (sys_rst)
    tick |=> !tick)
    else $error("Divider ticked on two adjacent cycles");
endmodule // adcs_tad_div
`default_nettype wire

// [core/adcs_top.sv]
// Converter control sequencer: registers, clock select, SAR stepping,
// result justification and pin configuration decode.
// Assumes a comparator answers comp_in for the code on sar_code.
//
// Design decisions made here: the strobed register port and the placing of the registers.
`timescale 1ns/1ps
`default_nettype none
`include "adcs_params.svh"
module adcs_top #(
  parameter int NUM_INPUTS = 8,
  parameter int RC_DIV     = `ADCS_RC_DIV
) (
  input  wire logic       clk,
  input  wire logic       sys_rst,
  input  wire logic [2:0] addr,
  input  wire logic [7:0] wdata,
  input  wire logic       wr,
  input  wire logic       rd,
  input  wire logic       comp_in,
  input  wire logic       sleep_mode,
  output var  logic [7:0] rdata,
  output var  logic [2:0] chan_sel,
  output var  logic       module_on,
  output var  logic       hold,
  output var  logic [9:0] sar_code,
  output var  logic       conv_flag,
  output var  logic [7:0] analog_mask,
  output var  logic       vref_pos_pin,
  output var  logic       vref_neg_pin
);
  adcs_pkg::adcs_state_t state;
  adcs_pkg::adcs_result_t result;
  logic [1:0]  clk_lo;
  logic [2:0]  chan;
  logic        power;
  logic        fmt_right;
  logic        clk_hi;
  logic [3:0]  port_cfg;
  logic [3:0]  step;
  logic [9:0]  trial;
  logic        done;
  logic        tad_tick;
  logic        tad_raw;
  logic        rc_sel;
  logic        stall;
  logic        busy;
  logic [15:0] period;
  logic        wr_main;
  logic        start;
  logic [7:0]  next_rdata;
  logic [7:0]  res_hi;
  logic [7:0]  res_lo;
  logic [7:0]  next_mask;
  logic        next_vpos;
  logic        next_vneg;
  logic [7:0]  exist_mask;

  assign busy    = (state == adcs_pkg::adcs_conv);
  assign wr_main = wr && (addr == `ADCS_OFF_MAIN);
  assign start   = wr_main && wdata[`ADCS_MAIN_GO] &&
                   wdata[`ADCS_MAIN_POWER] && !busy;
  assign rc_sel  = (clk_lo == 2'b11);
  // Oscillator stops in sleep; only the RC source keeps ticking
  assign stall   = sleep_mode && !rc_sel;

  // Control registers
  always_ff @(posedge clk) begin
    if (sys_rst) begin
      {clk_lo, chan, power} <= 6'h00;
    end else if (wr_main) begin
      clk_lo <= wdata[7:6];
      chan   <= wdata[5:3];
      power  <= wdata[`ADCS_MAIN_POWER];
    end
  end

  always_ff @(posedge clk) begin
    if (sys_rst) begin
      fmt_right <= 1'b0;
      clk_hi    <= 1'b0;
      port_cfg  <= 4'h0;
    end else if (wr && addr == `ADCS_OFF_FMT) begin
      fmt_right <= wdata[`ADCS_FMT_RIGHT];
      clk_hi    <= wdata[`ADCS_FMT_CLKHI];
      port_cfg  <= wdata[3:0];
    end
  end

  // Conversion clock selection
  always_comb begin
    case ({clk_hi, clk_lo})
      3'b000:  period = `ADCS_DIV_2;
      3'b001:  period = `ADCS_DIV_8;
      3'b010:  period = `ADCS_DIV_32;
      3'b100:  period = `ADCS_DIV_4;
      3'b101:  period = `ADCS_DIV_16;
      3'b110:  period = `ADCS_DIV_64;
      default: period = 16'(RC_DIV);
    endcase
  end

  adcs_tad_div #(
    .W (16)
  ) u_div (
    .clk     (clk),
    .sys_rst (sys_rst),
    .clr     (!busy),
    .en      (!stall),
    .period  (period),
    .tick    (tad_raw)
  );

  // A tick launched just before sleep must not step a paused conversion
  assign tad_tick = tad_raw && !stall;

  // Sequencer: step 0 holds the sample, 1..10 resolve bits, 11 finishes
  always_ff @(posedge clk) begin
    if (sys_rst) begin
      state <= adcs_pkg::adcs_idle;
      step  <= 4'h0;
      done  <= 1'b0;
    end else begin
      done <= 1'b0;
      case (state)
        adcs_pkg::adcs_idle: begin
          step <= 4'h0;
          if (start) begin
            state <= adcs_pkg::adcs_conv;
          end
        end
        adcs_pkg::adcs_conv: begin
          // Power bit written low aborts at once, not one cycle later
          if (!power || (wr_main && !wdata[`ADCS_MAIN_POWER])) begin
            state <= adcs_pkg::adcs_idle; // Power-off aborts
          end else if (tad_tick) begin
            if (step == `ADCS_LAST_STEP) begin
              state <= adcs_pkg::adcs_idle;
              done  <= 1'b1;
            end else begin
              step <= step + 4'h1;
            end
          end
        end
        default: state <= adcs_pkg::adcs_idle;
      endcase
    end
  end

  // Successive approximation register
  always_ff @(posedge clk) begin
    if (sys_rst) begin
      sar_code <= 10'h000;
      trial    <= 10'h000;
    end else if (start) begin
      sar_code <= `ADCS_TOP_TRIAL;
      trial    <= `ADCS_TOP_TRIAL;
    end else if (busy && tad_tick && step != 4'h0 &&
                 step != `ADCS_LAST_STEP) begin
      sar_code <= (comp_in ? sar_code : (sar_code & ~trial)) |
                  (trial >> 1);
      trial    <= trial >> 1;
    end
  end

  always_ff @(posedge clk) begin
    if (sys_rst) begin
      hold <= 1'b0;
    end else begin
      hold <= busy && power;
    end
  end

  // No reset: contents survive a power-on reset
  always_ff @(posedge clk) begin
    if (busy && tad_tick && step == `ADCS_LAST_STEP) begin
      result <= sar_code;
    end
  end

  always_ff @(posedge clk) begin
    if (sys_rst) begin
      conv_flag <= 1'b0;
    end else if (done) begin
      conv_flag <= 1'b1; // Set wins over a same-cycle clear
    end else if (wr && addr == `ADCS_OFF_FLAG && !wdata[`ADCS_FLAG_BIT]) begin
      conv_flag <= 1'b0;
    end
  end

  // Port configuration table
  always_comb begin
    next_vpos = 1'b0;
    next_vneg = 1'b0;
    case (port_cfg)
      4'h0: next_mask = 8'hff;
      4'h1: begin next_mask = 8'hf7; next_vpos = 1'b1; end
      4'h2: next_mask = 8'h1f;
      4'h3: begin next_mask = 8'h17; next_vpos = 1'b1; end
      4'h4: next_mask = 8'h0b;
      4'h5: begin next_mask = 8'h03; next_vpos = 1'b1; end
      4'h6, 4'h7: next_mask = 8'h00;
      4'h8: begin next_mask = 8'hf3; next_vpos = 1'b1; next_vneg = 1'b1; end
      4'h9: next_mask = 8'h3f;
      4'ha: begin next_mask = 8'h37; next_vpos = 1'b1; end
      4'hb: begin next_mask = 8'h33; next_vpos = 1'b1; next_vneg = 1'b1; end
      4'hc: begin next_mask = 8'h13; next_vpos = 1'b1; next_vneg = 1'b1; end
      4'hd: begin next_mask = 8'h03; next_vpos = 1'b1; next_vneg = 1'b1; end
      4'he: next_mask = 8'h01;
      default: begin next_mask = 8'h01; next_vpos = 1'b1; next_vneg = 1'b1; end
    endcase
  end

  // Pins beyond the package's inputs never report analog
  assign exist_mask = 8'((16'h0001 << NUM_INPUTS) - 16'h0001);

  always_ff @(posedge clk) begin
    if (sys_rst) begin
      analog_mask  <= `ADCS_MASK_RESET & exist_mask;
      vref_pos_pin <= 1'b0;
      vref_neg_pin <= 1'b0;
      chan_sel     <= 3'h0;
      module_on    <= 1'b0;
    end else begin
      analog_mask  <= next_mask & exist_mask;
      vref_pos_pin <= next_vpos;
      vref_neg_pin <= next_vneg;
      chan_sel     <= chan;
      module_on    <= power;
    end
  end

  // Read path: justification applied on read
  always_comb begin
    if (fmt_right) begin
      res_hi = {6'h00, result[9:8]};
      res_lo = result[7:0];
    end else begin
      res_hi = result[9:2];
      res_lo = {result[1:0], 6'h00};
    end
    case (addr)
      `ADCS_OFF_MAIN: next_rdata = {clk_lo, chan, busy, 1'b0, power};
      `ADCS_OFF_FMT:  next_rdata = {fmt_right, clk_hi, 2'b00, port_cfg};
      `ADCS_OFF_RESH: next_rdata = res_hi;
      `ADCS_OFF_RESL: next_rdata = res_lo;
      `ADCS_OFF_FLAG: next_rdata = {7'h00, conv_flag};
      default:        next_rdata = 8'h00;
    endcase
  end

  always_ff @(posedge clk) begin
    if (sys_rst) begin
      rdata <= 8'h00;
    end else if (rd) begin
      rdata <= next_rdata;
    end else begin
      rdata <= 8'h00;
    end
  end

  // Checks
  logic [4:0] tad_seen;
  always_ff @(posedge clk) begin
    if (sys_rst || start) begin
      tad_seen <= 5'h00;
    end else if (busy && tad_tick) begin
      tad_seen <= tad_seen + 5'h01;
    end
  end

  default clocking cb @(posedge clk); endclocking
  default disable iff (sys_rst);

  start_busy_a: assert property (start |=> busy)
    else $error("Go write did not start a conversion");
  off_nostart_a: assert property (
    wr_main && !wdata[`ADCS_MAIN_POWER] |=> !busy)
    else $error("Conversion ran while powered off");
  done_clear_a: assert property (done |-> !busy ##1 conv_flag)
    else $error("Completion did not clear go and set flag");
  twelve_tad_a: assert property (
    done |-> tad_seen == 5'(`ADCS_CONV_TADS))
    else $error("Conversion length is not twelve clock periods");
  flag_hold_a: assert property (
    conv_flag && !(wr && addr == `ADCS_OFF_FLAG) |=> conv_flag)
    else $error("Interrupt flag dropped without a clear");
  rst_state_a: assert property (
    $past(sys_rst) |-> !busy && !power &&
    analog_mask == (`ADCS_MASK_RESET & exist_mask))
    else $error("Reset did not restore control state");
  rsv_zero_a: assert property (
    rd && addr == `ADCS_OFF_MAIN |=> rdata[1] == 1'b0)
    else $error("Unimplemented main bit read as one");
  right_just_a: assert property (
    rd && addr == `ADCS_OFF_RESH && fmt_right |=> rdata[7:2] == 6'h00)
    else $error("Right justified high byte not zero extended");
  sleep_stall_a: assert property (
    busy && stall |=> step == $past(step))
    else $error("Conversion advanced in sleep without RC clock");
  left_just_a: assert property (
    rd && addr == `ADCS_OFF_RESL && !fmt_right |=> rdata[5:0] == 6'h00)
    else $error("Left justified low byte not zero filled");
  fmt_rsv_a: assert property (
    rd && addr == `ADCS_OFF_FMT |=> rdata[5:4] == 2'b00)
    else $error("Unimplemented format bits read as one");
  go_read_a: assert property (
    rd && addr == `ADCS_OFF_MAIN |=> rdata[`ADCS_MAIN_GO] == $past(busy))
    else $error("Go bit read differs from conversion state");
  chan_route_a: assert property (
    wr_main |=> ##1 chan_sel == $past(wdata[5:3], 2))
    else $error("Channel output does not follow the written field");
  power_off_a: assert property (!power |=> !hold)
    else $error("Sample held while the module is off");
  // Only bites on the small package build
  mask_exist_a: assert property (
    (analog_mask & ~exist_mask) == 8'h00)
    else $error("Missing pin reported as analog");
  flag_clear_a: assert property (
    wr && addr == `ADCS_OFF_FLAG && !wdata[`ADCS_FLAG_BIT] && !done
    |=> !conv_flag)
    else $error("Interrupt flag survived a clear");

  conv_done_c: cover property (start ##[1:1000] done);
  rc_conv_c:   cover property (done && rc_sel);
  read_res_c:  cover property (done ##[1:20] (rd && addr == `ADCS_OFF_RESL));
  sleep_pause_c: cover property (busy && stall && sleep_mode);
  pwr_abort_c:   cover property (busy && wr_main && !wdata[`ADCS_MAIN_POWER]);
endmodule // adcs_top
`default_nettype wire

// [verif/adcs_analog_model.sv]
// Far-side model: analog input levels and the comparator.
// Assumes the sequencer holds chan_sel and sar_code steady between ticks.
`timescale 1ns/1ps
`default_nettype none
module adcs_analog_model (
  input  wire logic       clk,
  input  wire logic [2:0] chan_sel,
  input  wire logic       hold,
  input  wire logic [9:0] sar_code,
  output var  logic       comp_in
);
  logic [9:0] level [8];
  logic       junk;
  initial level = '{10'h000, 10'h3ff, 10'h155, 10'h2aa,
                    10'h001, 10'h200, 10'h1ff, 10'h3a5};
  // No sample held means no meaningful answer: toggle every cycle
  initial junk = 1'b0;
  always @(posedge clk) begin
    junk <= ~junk;
  end
  always_comb begin
    comp_in = hold ? (level[chan_sel] >= sar_code) : junk;
  end
endmodule // adcs_analog_model
`default_nettype wire

// [verif/tb_adcs_top.sv]
// Self-checking bench for the converter control sequencer.
// Assumes the far-side model; the RC tick is shortened to RC cycles.
`timescale 1ns/1ps
`default_nettype none
module tb_adcs_top;
  localparam int RC = 4;
  localparam logic [9:0] PTAB [16] = '{10'h3fc, 10'h3de, 10'h07c, 10'h05e,
    10'h02c, 10'h00e, 10'h000, 10'h000, 10'h3cf, 10'h0fc, 10'h0de, 10'h0cf,
    10'h04f, 10'h00f, 10'h004, 10'h007};
  logic       clk = 1'b0;
  logic       sys_rst = 1'b1;
  logic       wr = 1'b0;
  logic       rd = 1'b0;
  logic       sleep_mode = 1'b0;
  logic [2:0] addr = 3'h0;
  logic [7:0] wdata = 8'h00;
  logic [7:0] rdata, analog_mask;
  logic [2:0] chan_sel;
  logic [9:0] sar_code;
  logic       comp_in, module_on, hold, conv_flag, vref_pos_pin, vref_neg_pin;
  int         bad_count = 0;
  int         samples_checked = 0;
  always #5 clk = ~clk;
  adcs_top #(.NUM_INPUTS(8), .RC_DIV(RC)) u_dut (.clk(clk), .sys_rst(sys_rst),
    .addr(addr), .wdata(wdata), .wr(wr), .rd(rd), .comp_in(comp_in),
    .sleep_mode(sleep_mode), .rdata(rdata), .chan_sel(chan_sel),
    .module_on(module_on), .hold(hold), .sar_code(sar_code),
    .conv_flag(conv_flag), .analog_mask(analog_mask),
    .vref_pos_pin(vref_pos_pin), .vref_neg_pin(vref_neg_pin));
  adcs_analog_model u_model (.clk(clk), .chan_sel(chan_sel), .hold(hold),
    .sar_code(sar_code), .comp_in(comp_in));
  task automatic check(input string name, input logic [15:0] seen, exp);
    samples_checked++;
    if (seen !== exp) begin
      bad_count++;
      $display("MISMATCH %s expected %h seen %h", name, exp, seen);
    end
  endtask
  task automatic results();
    $display("checks %0d mismatches %0d", samples_checked, bad_count);
    if (bad_count == 0 && samples_checked > 0) begin
      $display("Run complete: PASS");
    end else begin
      $display("Run complete: FAIL");
    end
    $finish;
  endtask
  task automatic wreg(input logic [2:0] a, input logic [7:0] d);
    @(posedge clk);
    wr <= 1'b1;
    addr <= a;
    wdata <= d;
    @(posedge clk);
    wr <= 1'b0;
  endtask
  task automatic rreg(input logic [2:0] a, output logic [7:0] d);
    @(posedge clk);
    rd <= 1'b1;
    addr <= a;
    @(posedge clk);
    rd <= 1'b0;
    #1 d = rdata;
  endtask
  // Counts cycles with hold high; a hang ends the run
  task automatic wait_conv(output int n);
    n = 0;
    for (int i = 0; i < 2000; i++) begin
      @(posedge clk);
      #1;
      if (hold === 1'b1) n++;
      else if (n > 0) return;
    end
    bad_count++;
    results();
  endtask
  task automatic conv(input logic [2:0] ck, ch, input logic rj);
    int         d, n;
    logic [7:0] v, h, l;
    logic [9:0] r;
    d = (ck[1:0] == 2'b11) ? RC : (2 << (2 * ck[1:0] + ck[2]));
    r = u_model.level[ch];
    wreg(3'h4, 8'h00);
    #1 check("flag clr", conv_flag, 1'b0);
    wreg(3'h1, {rj, ck[2], 6'h00});
    wreg(3'h0, {ck[1:0], ch, 3'b101});
    #1 check("trial", sar_code, 10'h200);
    wait_conv(n);
    check("cycles", 16'(n >= 12 * d && n <= 12 * d + 4), 16'h1);
    check("chan_sel", chan_sel, ch);
    rreg(3'h0, v);
    check("main", v, {ck[1:0], ch, 3'b001});
    rreg(3'h4, v);
    check("flag", v[0], 1'b1);
    rreg(3'h2, h);
    rreg(3'h3, l);
    check("result", {h, l}, rj ? {6'h00, r} : {r, 6'h00});
    repeat (2 * d) @(posedge clk);
  endtask
  initial begin
    logic [7:0] v, h;
    int         n;
    repeat (2) @(posedge clk);
    sys_rst <= 1'b0;
    #1;
    check("pins", {analog_mask, vref_pos_pin, vref_neg_pin}, 10'h3fc);
    check("on", {module_on, hold, conv_flag}, 3'h0);
    wreg(3'h0, 8'h02);
    rreg(3'h0, v);
    check("main bit1", v, 8'h00);
    wreg(3'h1, 8'h30);
    rreg(3'h1, v);
    check("fmt bits54", v, 8'h00);
    rreg(3'h5, v);
    check("unmapped", v, 8'h00);
    wreg(3'h0, 8'h04);
    repeat (4) @(posedge clk);
    #1 check("go while off", {hold, module_on}, 2'b00);
    wreg(3'h0, 8'h01);
    repeat (2) @(posedge clk);
    #1 check("power", module_on, 1'b1);
    // Large variant: channel codes 5..7 exist here
    for (int k = 0; k < 8; k++) conv(3'(k), 3'(k), k[0]);
    for (int c = 0; c < 16; c++) begin
      wreg(3'h1, 8'(c));
      repeat (2) @(posedge clk);
      #1 check("pins", {analog_mask, vref_pos_pin, vref_neg_pin}, PTAB[c]);
    end
    wreg(3'h1, 8'h00);
    wreg(3'h0, 8'h05);
    @(posedge clk);
    sleep_mode <= 1'b1;
    repeat (40) @(posedge clk);
    rreg(3'h0, v);
    check("paused", {v[2], hold}, 2'b11);
    @(posedge clk);
    sleep_mode <= 1'b0;
    wait_conv(n);
    repeat (4) @(posedge clk);
    // Software picks the RC clock before sleeping; channel 1 is nonzero
    wreg(3'h0, 8'hcd);
    @(posedge clk);
    sleep_mode <= 1'b1;
    wait_conv(n);
    check("rc sleep", 16'(n >= 12 * RC && n <= 12 * RC + 4), 16'h1);
    @(posedge clk);
    sleep_mode <= 1'b0;
    rreg(3'h2, h);
    check("rc result", h, u_model.level[1][9:2]);
    wreg(3'h1, 8'h0f);
    wreg(3'h0, 8'hc5);
    @(posedge clk);
    sys_rst <= 1'b1;
    repeat (2) @(posedge clk);
    sys_rst <= 1'b0;
    @(posedge clk);
    #1 check("rst pins", {analog_mask, vref_pos_pin, vref_neg_pin}, 10'h3fc);
    check("abort", {module_on, hold}, 2'b00);
    rreg(3'h0, v);
    check("main rst", v, 8'h00);
    rreg(3'h2, v);
    check("kept", v, h);
    results();
  end
endmodule // tb_adcs_top
`default_nettype wire
